// ==== hw/assw_cfg.svh ====
/*
  constants for the arithmetic and scan status word: offsets, bit
  positions, reset values and the fault code.
  assumes inclusion by bare name from the design file.
*/
`ifndef ASSW_CFG_SVH
`define ASSW_CFG_SVH
`define ASSW_OFF_FLAGS    4'h0
`define ASSW_OFF_MINOR    4'h1
`define ASSW_OFF_IRQ_STAT 4'h2
`define ASSW_OFF_IRQ_MASK 4'h3
`define ASSW_OFF_FAULT    4'h4
`define ASSW_BIT_CARRY    0
`define ASSW_BIT_OVFL     1
`define ASSW_BIT_ZERO     2
`define ASSW_BIT_SIGN     3
`define ASSW_BIT_EXT_IO   8
`define ASSW_BIT_PRIM     10
`define ASSW_BIT_ACT      11
`define ASSW_BIT_HALFDUP  12
`define ASSW_FLAGS_WMASK  16'h1d0f
`define ASSW_FLAGS_RESET  16'h0000
`define ASSW_FAULT_UNUSED 8'h41
`define ASSW_IRQ_OVTRAP   0
`define ASSW_IRQ_FAULT    1
`define ASSW_IRQ_PSWITCH  2
`endif

// ==== hw/assw_pkg.sv ====
/*
  types for the arithmetic and scan status word.
  assumes the config header sits beside it.
*/
package assw_pkg;
  // routine nesting: main program or an interrupting routine
  typedef enum logic [0:0] {
    ASSW_MAIN = 1'b0,
    ASSW_INTR = 1'b1
  } assw_ctx_t;
endpackage

// ==== hw/assw_status_word.sv ====
/*
  status word register bank: arithmetic flags, unused output enable,
  protocol selection and report, minor error trap, interrupt logic.
  assumes the instruction engine and comms logic share clk; register
  port strobes are single cycle and never overlap.
*/
// What this block does
// - carry is set on an unsigned carry or borrow and cleared otherwise.
// - overflow is set when a result does not fit and cleared otherwise.
// - a set overflow also sets the minor overflow trap unless encoding.
// - zero is set when a qualifying result is zero, else cleared.
// - sign is set when a qualifying result is negative, else cleared.
// - the arithmetic flags hold until the next qualifying instruction, flags word write or routine return.
// - an interrupting routine saves the flags and restores them on return.
// - with the unused output enable clear, an unused output faults 41h.
// - the primary protocol bit picks the first protocol, 0 is protocol a.
// - the active protocol bit follows every protocol switch.
// - a read-only bit reports the protocol a variant, 1 is half duplex.
// - dynamic configuration bits are taken while online and running.
`include "assw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module assw_status_word
  import assw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        alu_valid,
  input  wire logic        alu_carry,
  input  wire logic        alu_ovfl,
  input  wire logic        alu_zero,
  input  wire logic        alu_sign,
  input  wire logic        encode_instruction,
  input  wire logic        routine_enter,
  input  wire logic        routine_exit,
  input  wire logic        unused_output_on,
  input  wire logic        proto_switch,
  input  wire logic        proto_new,
  input  wire logic        half_duplex_cfg,
  output logic             primary_protocol,
  output logic             unused_out_enable,
  output logic             fault_active,
  output logic      [7:0]  fault_code,
  output logic             irq
);

  logic [3:0]  arith_q, arith_d;      // carry, overflow, zero, sign
  logic [3:0]  saved_q, saved_d;      // flags held across a routine
  assw_ctx_t   ctx_q, ctx_d;
  logic        ext_io_q, ext_io_d;
  logic        prim_q, prim_d;
  logic        act_q, act_d;
  logic        ovtrap_q, ovtrap_d;
  logic        fault_q, fault_d;
  logic [7:0]  fcode_q, fcode_d;
  logic [2:0]  ist_q, ist_d;
  logic [2:0]  imask_q, imask_d;
  logic [15:0] rdata_q, rdata_d;
  logic [2:0]  ev;

  // address decode used by the write paths; the read mux decodes in its case
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // the composed status word, reserved positions forced low
  function automatic logic [15:0] word(input logic [3:0] f, input logic e,
                                       input logic p, input logic a,
                                       input logic h);
    word = 16'h0000;
    word[3:0] = f;
    word[`ASSW_BIT_EXT_IO] = e;
    word[`ASSW_BIT_PRIM] = p;
    word[`ASSW_BIT_ACT] = a;
    word[`ASSW_BIT_HALFDUP] = h;
  endfunction

  logic wr_flags;
  assign wr_flags = reg_wr && hit(reg_addr, `ASSW_OFF_FLAGS);

  // next state of flags, context save and configuration bits
  always_comb begin
    arith_d  = arith_q;
    saved_d  = saved_q;
    ctx_d    = ctx_q;
    ext_io_d = ext_io_q;
    prim_d   = prim_q;
    act_d    = act_q;
    ovtrap_d = ovtrap_q;
    fault_d  = fault_q;
    fcode_d  = fcode_q;
    // software write first so hardware updates below win the cycle
    if (wr_flags) begin
      arith_d  = reg_wdata[3:0];
      ext_io_d = reg_wdata[`ASSW_BIT_EXT_IO];
      prim_d   = reg_wdata[`ASSW_BIT_PRIM];
      act_d    = reg_wdata[`ASSW_BIT_ACT];
    end
    if (reg_wr && hit(reg_addr, `ASSW_OFF_MINOR) &&
        reg_wdata[0])
      ovtrap_d = 1'b0;
    if (reg_wr && hit(reg_addr, `ASSW_OFF_FAULT) && reg_wdata[0]) begin
      fault_d = 1'b0;
      fcode_d = 8'h00;
    end
    // an interrupting routine snapshots the flags on entry
    if (routine_enter && ctx_q == ASSW_MAIN) begin
      saved_d = arith_q;
      ctx_d   = ASSW_INTR;
    end
    if (alu_valid) begin
      arith_d[`ASSW_BIT_CARRY] = alu_carry;
      arith_d[`ASSW_BIT_OVFL]  = alu_ovfl;
      arith_d[`ASSW_BIT_ZERO]  = alu_zero;
      arith_d[`ASSW_BIT_SIGN]  = alu_sign;
      if (alu_ovfl && !encode_instruction)
        ovtrap_d = 1'b1;
    end
    // restore beats any update from the last routine cycle
    if (routine_exit && ctx_q == ASSW_INTR) begin
      arith_d = saved_q;
      ctx_d   = ASSW_MAIN;
    end
    if (unused_output_on && !ext_io_q) begin
      fault_d = 1'b1;
      fcode_d = `ASSW_FAULT_UNUSED;
    end
    if (proto_switch)
      act_d = proto_new;
  end

  // events feeding the sticky interrupt status
  assign ev[`ASSW_IRQ_OVTRAP]  = alu_valid && alu_ovfl &&
                                 !encode_instruction;
  assign ev[`ASSW_IRQ_FAULT]   = unused_output_on && !ext_io_q;
  assign ev[`ASSW_IRQ_PSWITCH] = proto_switch;

  // write one to clear; a same-cycle event keeps its bit set
  always_comb begin
    ist_d   = ist_q;
    imask_d = imask_q;
    if (reg_wr && hit(reg_addr, `ASSW_OFF_IRQ_STAT))
      ist_d = ist_q & ~reg_wdata[2:0];
    ist_d = ist_d | ev;
    if (reg_wr && hit(reg_addr, `ASSW_OFF_IRQ_MASK))
      imask_d = reg_wdata[2:0];
  end

  // read mux, answer stands one cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `ASSW_OFF_FLAGS:    rdata_d = word(arith_q, ext_io_q, prim_q,
                                           act_q, half_duplex_cfg);
        `ASSW_OFF_MINOR:    rdata_d = {15'h0000, ovtrap_q};
        `ASSW_OFF_IRQ_STAT: rdata_d = {13'h0000, ist_q};
        `ASSW_OFF_IRQ_MASK: rdata_d = {13'h0000, imask_q};
        `ASSW_OFF_FAULT:    rdata_d = {fcode_q, 7'h00, fault_q};
        default:            rdata_d = 16'h0000;
      endcase
    end
  end

  // all state registers; clk_en low freezes everything
  always_ff @(posedge clk) begin
    if (reset) begin
      arith_q  <= 4'(`ASSW_FLAGS_RESET);
      saved_q  <= 4'h0;
      ctx_q    <= ASSW_MAIN;
      ext_io_q <= 1'b0;
      prim_q   <= 1'b0;
      act_q    <= 1'b0;
      ovtrap_q <= 1'b0;
      fault_q  <= 1'b0;
      fcode_q  <= 8'h00;
      ist_q    <= 3'h0;
      imask_q  <= 3'h0;
      rdata_q  <= 16'h0000;
    end else if (clk_en) begin
      arith_q  <= arith_d;
      saved_q  <= saved_d;
      ctx_q    <= ctx_d;
      ext_io_q <= ext_io_d;
      prim_q   <= prim_d;
      act_q    <= act_d;
      ovtrap_q <= ovtrap_d;
      fault_q  <= fault_d;
      fcode_q  <= fcode_d;
      ist_q    <= ist_d;
      imask_q  <= imask_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata         = rdata_q;
  assign primary_protocol  = prim_q;
  assign unused_out_enable = ext_io_q;
  assign fault_active      = fault_q;
  assign fault_code        = fcode_q;
  assign irq               = |(ist_q & imask_q);

endmodule

`default_nettype wire

// ==== verification/assw_sva.sv ====
/*
  port checker for the arithmetic and scan status word.
  assumes it is bound to the top module; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module assw_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        unused_output_on,
  input wire logic        primary_protocol,
  input wire logic        unused_out_enable,
  input wire logic        fault_active,
  input wire logic [7:0]  fault_code,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic w0;
  // a taken write of the flags word
  assign w0 = clk_en && reg_wr && reg_addr == 4'h0;
  reserved_bits_a: assert property (
    clk_en && reg_rd && reg_addr == 4'h0
    |=> (reg_rdata & 16'he2f0) == 16'h0000) else $error("resv");
  idle_rdata_a: assert property (
    clk_en && !reg_rd |=> reg_rdata == 16'h0000) else $error("idle");
  ext_write_a: assert property (
    w0 |=> unused_out_enable == $past(reg_wdata[8])) else $error("ext");
  prim_write_a: assert property (
    w0 |=> primary_protocol == $past(reg_wdata[10])) else $error("prim");
  prim_hold_a: assert property (
    !w0 |=> $stable(primary_protocol)) else $error("prim hold");
  // fault must carry its code from the first cycle it shows
  unused_fault_a: assert property (
    clk_en && unused_output_on && !unused_out_enable && !reg_wr
    |=> fault_active && fault_code == 8'h41) else $error("fault");
  fault_hold_a: assert property (
    fault_active && !reg_wr |=> fault_active) else $error("fault hold");
  irq_mask_a: assert property (
    clk_en && reg_wr && reg_addr == 4'h3 && reg_wdata == 16'h0000
    |=> !irq) else $error("mask");
  cover property (w0);
  cover property (fault_active);
  cover property (irq);
endmodule
bind assw_status_word assw_sva assw_sva_inst (.*);
`default_nettype wire

// ==== verification/tb.sv ====
/*
  self-checking bench for the status word register bank.
  assumes the design alone, clocked at 250 MHz, no partner.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import assw_pkg::*;
  logic clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic alu_valid = 0, alu_carry = 0, alu_ovfl = 0, alu_zero = 0;
  logic alu_sign = 0, encode_instruction = 0, routine_enter = 0;
  logic routine_exit = 0, unused_output_on = 0, proto_switch = 0;
  logic proto_new = 0, half_duplex_cfg = 0, primary_protocol, irq;
  logic unused_out_enable, fault_active;
  logic [7:0] fault_code;
  int n_errors = 0, check_count = 0, cyc = 0;
  assw_status_word assw_status_word_inst (.*);
  always #2 clk = ~clk;
  task automatic end_of_test();
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard: the sequence needs fewer than a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc >= 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic alu(input logic [4:0] f);
    @(posedge clk) begin
      alu_valid <= 1;
      {encode_instruction, alu_sign, alu_zero, alu_ovfl, alu_carry} <= f;
    end
    @(posedge clk) alu_valid <= 0;
    #1;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    rd(4'h0, 16'h0000);
    wr(4'h3, 16'h0007);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h0d0f);
    chk(primary_protocol, 1);
    alu(5'b01001);
    rd(4'h0, 16'h0d09);
    alu(5'b10110);
    rd(4'h0, 16'h0d06);
    rd(4'h1, 16'h0000);
    alu(5'b00010);
    rd(4'h1, 16'h0001);
    chk(irq, 1);
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h0001);
    chk(irq, 0);
    rd(4'h0, 16'h0d02);
    @(posedge clk) routine_enter <= 1;
    @(posedge clk) routine_enter <= 0;
    alu(5'b00101);
    rd(4'h0, 16'h0d05);
    @(posedge clk) routine_exit <= 1;
    @(posedge clk) routine_exit <= 0;
    rd(4'h0, 16'h0d02);
    @(posedge clk) {proto_switch, proto_new} <= 2'b10;
    @(posedge clk) proto_switch <= 0;
    rd(4'h0, 16'h0502);
    chk(irq, 1);
    wr(4'h2, 16'h0004);
    @(posedge clk) half_duplex_cfg <= 1;
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h1000);
    chk(unused_out_enable, 0);
    @(posedge clk) unused_output_on <= 1;
    @(posedge clk) unused_output_on <= 0;
    rd(4'h4, 16'h4101);
    chk(fault_code, 8'h41);
    wr(4'h4, 16'h0001);
    wr(4'h2, 16'h0002);
    chk(fault_active, 0);
    wr(4'h0, 16'h0100);
    @(posedge clk) unused_output_on <= 1;
    @(posedge clk) unused_output_on <= 0;
    #1 chk(fault_active, 0);
    // clock enable low must freeze the flags word
    @(posedge clk) clk_en <= 0;
    alu(5'b00001);
    @(posedge clk) clk_en <= 1;
    rd(4'h0, 16'h1100);
    rd(4'hf, 16'h0000);
    wr(4'h3, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
